// *** core/vfd_pkg.sv ***
package vfd_pkg;

  // ******************************************************************
  // Packet geometry
  // ******************************************************************
  localparam int FETCH_BITS = 256;
  localparam int SLOT_BITS = 32;
  localparam int SLOTS = 8;
  localparam int NUM_REGS = 16;
  localparam int REG_BITS = 32;
  localparam int DWORD_BITS = 64;

  // ******************************************************************
  // Instruction fields
  // ******************************************************************
  localparam int CHAIN_POS = 0;
  localparam int UNIT_LSB = 1;
  localparam int SIDE_POS = 4;
  localparam int OPC_LSB = 5;
  localparam int OFFMODE_POS = 8;
  localparam int CIRC_POS = 9;
  localparam int XPATH_POS = 10;
  localparam int DST_LSB = 11;
  localparam int SRC_LSB = 15;
  localparam int SRC2_LSB = 19;
  localparam int OFF_LSB = 15;
  localparam int OFF_SHORT_BITS = 5;
  localparam int OFF_LONG_BITS = 15;
  localparam int CREG_LSB = 29;
  localparam int ZFLAG_POS = 28;

  // Condition select 0 means unconditional
  localparam logic [2:0] CREG_ALWAYS = 3'h0;
  localparam logic [4:0] NOP_WORD_OPC = 5'h00;

  // Unit class within a side
  typedef enum logic [1:0] {
    VFD_UNIT_LOGIC = 2'h0,
    VFD_UNIT_SHIFT = 2'h1,
    VFD_UNIT_MULT = 2'h2,
    VFD_UNIT_DATA = 2'h3
  } vfd_unit_type;

  // Opcodes per class (low three bits of opcode field)
  localparam logic [2:0] OP_ADD = 3'h1;
  localparam logic [2:0] OP_AND = 3'h2;
  localparam logic [2:0] OP_BRANCH = 3'h3;
  localparam logic [2:0] OP_SHL = 3'h4;
  localparam logic [2:0] OP_MUL = 3'h5;
  localparam logic [2:0] OP_LOAD = 3'h6;
  localparam logic [2:0] OP_STORE = 3'h7;
  localparam logic [2:0] OP_LOAD_DOUBLE_WORD = 3'h2;

  typedef enum logic [1:0] {
    VFD_SIZE_BYTE = 2'h0,
    VFD_SIZE_HALF = 2'h1,
    VFD_SIZE_WORD = 2'h2,
    VFD_SIZE_DWORD = 2'h3
  } vfd_size_type;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic valid;
    logic wr;
    vfd_size_type size;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [3:0] dst;
    logic dst_side;
  } vfd_mem_req_type;

  typedef struct packed {
    logic valid;
    logic [63:0] rdata;
    logic [3:0] dst;
    logic dst_side;
  } vfd_mem_rsp_type;

  typedef enum logic [1:0] {
    VFD_ST_FETCH = 2'h0,
    VFD_ST_WAIT = 2'h1,
    VFD_ST_ISSUE = 2'h3
  } vfd_state_type;

endpackage : vfd_pkg

// *** core/vfd_core.sv ***
module vfd_core (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  output logic fetch_req_o,
  output logic [31:0] fetch_addr_o,
  input wire logic fetch_valid_i,
  input wire logic [vfd_pkg::FETCH_BITS-1:0] fetch_data_i,
  output vfd_pkg::vfd_mem_req_type mem_req_a_o,
  output vfd_pkg::vfd_mem_req_type mem_req_b_o,
  input wire vfd_pkg::vfd_mem_rsp_type mem_rsp_i,
  input wire logic [7:0] circ_size_i,
  output logic [vfd_pkg::SLOTS-1:0] issue_mask_o,
  output logic packet_issued_o,
  output logic [31:0] pc_o
);
  import vfd_pkg::*;

  // ******************************************************************
  // Fetch and packet splitting
  // ******************************************************************
  vfd_state_type state_r;
  logic [FETCH_BITS-1:0] fp_r;
  logic [SLOTS-1:0] done_r;
  logic [31:0] pc_r;
  logic [SLOTS-1:0] ep_mask;
  logic ep_last;
  logic branch_taken;
  logic [31:0] branch_target;

  // Execute packet = lowest undone slot plus chained followers
  always_comb begin
    logic run;
    run = 1'b1;
    ep_mask = '0;
    ep_last = 1'b1;
    for (int s = 0; s < SLOTS; s++) begin
      if (!done_r[s] && run) begin
        ep_mask[s] = 1'b1;
        run = fp_r[s*SLOT_BITS + CHAIN_POS];
      end
    end
    // Packet is last when nothing above it remains
    for (int s = 0; s < SLOTS; s++) begin
      if (!done_r[s] && !ep_mask[s]) begin
        ep_last = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_r <= VFD_ST_FETCH;
      done_r <= '1;
      fp_r <= '0;
    end else begin
      case (state_r)
        VFD_ST_FETCH: begin
          state_r <= VFD_ST_WAIT;
        end
        VFD_ST_WAIT: begin
          if (fetch_valid_i) begin
            fp_r <= fetch_data_i;
            done_r <= '0;
            state_r <= VFD_ST_ISSUE;
          end
        end
        VFD_ST_ISSUE: begin
          done_r <= done_r | ep_mask;
          if (ep_last || branch_taken) begin
            state_r <= VFD_ST_FETCH;
          end
        end
        default: begin
          state_r <= VFD_ST_FETCH;
        end
      endcase
    end
  end

  // Program counter advances a whole packet at a time
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pc_r <= 32'h0000_0000;
    end else if (state_r == VFD_ST_ISSUE && branch_taken) begin
      pc_r <= {branch_target[31:5], 5'h00};
    end else if (state_r == VFD_ST_ISSUE && ep_last) begin
      pc_r <= pc_r + 32'h0000_0020;
    end
  end

  assign fetch_req_o = (state_r == VFD_ST_WAIT);
  assign fetch_addr_o = pc_r;
  assign pc_o = pc_r;

  // ******************************************************************
  // Register files and condition evaluation
  // ******************************************************************
  logic [REG_BITS-1:0] rf_r [2][NUM_REGS];

  // Condition register test; select 0 always passes
  function automatic logic cond_pass(input logic [31:0] ins,
                                     input logic [REG_BITS-1:0] rfa [NUM_REGS]);
    logic nz;
    nz = (rfa[{1'b0, ins[CREG_LSB +: 3]}] != '0);
    if (ins[CREG_LSB +: 3] == CREG_ALWAYS) begin
      cond_pass = 1'b1;
    end else begin
      cond_pass = ins[ZFLAG_POS] ? !nz : nz;
    end
  endfunction : cond_pass

  logic [SLOTS-1:0] act;
  logic [31:0] slot_ins [SLOTS];
  logic [REG_BITS-1:0] wr_val [SLOTS];
  logic [SLOTS-1:0] wr_en;
  logic [SLOTS-1:0] xread;
  logic [SLOTS-1:0] br_en;
  vfd_mem_req_type mreq [2];

  // Operand fetch: same side freely, other side through the cross path
  function automatic logic [REG_BITS-1:0] rd_op(input logic sd, input logic xp,
                                                input logic [3:0] idx,
                                                input logic [REG_BITS-1:0] ra [NUM_REGS],
                                                input logic [REG_BITS-1:0] rb [NUM_REGS]);
    logic use_b;
    use_b = sd ^ xp;
    rd_op = use_b ? rb[idx] : ra[idx];
  endfunction : rd_op

  // Signed offset, short or long form
  function automatic logic [31:0] offset_of(input logic [31:0] ins);
    if (ins[OFFMODE_POS]) begin
      offset_of = {{17{ins[OFF_LSB+OFF_LONG_BITS-1]}}, ins[OFF_LSB +: OFF_LONG_BITS]};
    end else begin
      offset_of = {{27{ins[OFF_LSB+OFF_SHORT_BITS-1]}}, ins[OFF_LSB +: OFF_SHORT_BITS]};
    end
  endfunction : offset_of

  generate
    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      logic [REG_BITS-1:0] op1;
      logic [REG_BITS-1:0] op2;
      logic sd;
      vfd_unit_type ucls;
      logic [2:0] opc;
      assign slot_ins[s] = fp_r[s*SLOT_BITS +: SLOT_BITS];
      assign sd = slot_ins[s][SIDE_POS];
      assign ucls = vfd_unit_type'(slot_ins[s][UNIT_LSB +: 2]);
      assign opc = slot_ins[s][OPC_LSB +: 3];
      assign op1 = rd_op(sd, slot_ins[s][XPATH_POS], slot_ins[s][SRC_LSB +: 4],
                         rf_r[0], rf_r[1]);
      assign op2 = rd_op(sd, 1'b0, slot_ins[s][SRC2_LSB +: 4], rf_r[0], rf_r[1]);
      assign act[s] = (state_r == VFD_ST_ISSUE) && ep_mask[s]
                      && cond_pass(slot_ins[s], rf_r[sd]);
      always_comb begin
        wr_val[s] = '0;
        wr_en[s] = 1'b0;
        br_en[s] = 1'b0;
        case (ucls)
          VFD_UNIT_MULT: begin
            if (opc == OP_MUL) begin
              wr_val[s] = {16'h0000, op1[15:0]} * {16'h0000, op2[15:0]};
              wr_en[s] = act[s];
            end
          end
          VFD_UNIT_LOGIC, VFD_UNIT_SHIFT: begin
            // On shift units code 2 is the double load, so it must not also write back
            wr_en[s] = act[s] && (opc == OP_ADD || opc == OP_SHL
                                  || (opc == OP_AND && ucls == VFD_UNIT_LOGIC));
            if (opc == OP_ADD) begin
              wr_val[s] = op1 + op2;
            end else if (opc == OP_AND) begin
              wr_val[s] = op1 & op2;
            end else if (opc == OP_SHL) begin
              wr_val[s] = op1 << op2[4:0];
            end
            br_en[s] = act[s] && (opc == OP_BRANCH);
          end
          default: begin
          end
        endcase
      end
      assign xread[s] = act[s] && slot_ins[s][XPATH_POS];
    end
  endgenerate

  // ******************************************************************
  // Data-address units and shift-unit double loads
  // ******************************************************************
  generate
    for (genvar sd = 0; sd < 2; sd++) begin : g_side
      always_comb begin
        logic [31:0] base;
        logic [31:0] lin;
        logic [31:0] ins;
        base = '0;
        lin = '0;
        ins = '0;
        mreq[sd] = '0;
        for (int s = 0; s < SLOTS; s++) begin
          if (act[s] && slot_ins[s][SIDE_POS] == 1'(sd)) begin
            ins = slot_ins[s];
            base = ins[XPATH_POS] ? rf_r[1-sd][ins[SRC2_LSB +: 4]]
                                  : rf_r[sd][ins[SRC2_LSB +: 4]];
            if (ins[UNIT_LSB +: 2] == VFD_UNIT_DATA && ins[OPC_LSB +: 2] != 2'h0) begin
              lin = base + offset_of(ins);
              if (ins[CIRC_POS]) begin
                lin = {base[31:8], lin[7:0] & circ_size_i};
              end
              mreq[sd].valid = 1'b1;
              mreq[sd].wr = (ins[OPC_LSB +: 3] == OP_STORE);
              mreq[sd].size = vfd_size_type'(ins[OPC_LSB+3 +: 2]);
              if (mreq[sd].size == VFD_SIZE_DWORD) begin
                mreq[sd].size = VFD_SIZE_WORD;
              end
              mreq[sd].addr = lin;
              mreq[sd].wdata = {32'h0000_0000, rf_r[ins[XPATH_POS] ? sd : 1-sd]
                                               [ins[DST_LSB +: 4]]};
              mreq[sd].dst = ins[DST_LSB +: 4];
              mreq[sd].dst_side = ins[XPATH_POS] ? 1'(sd) : ~1'(sd);
            end else if (ins[UNIT_LSB +: 2] == VFD_UNIT_SHIFT
                         && ins[OPC_LSB +: 3] == OP_LOAD_DOUBLE_WORD) begin
              mreq[sd].valid = 1'b1;
              mreq[sd].size = VFD_SIZE_DWORD;
              mreq[sd].addr = {base[31:3], 3'h0};
              mreq[sd].dst = ins[DST_LSB +: 4];
              mreq[sd].dst_side = 1'(sd);
            end
          end
        end
      end
    end
  endgenerate

  // Request outputs registered so data comes from flip-flops
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mem_req_a_o <= '0;
      mem_req_b_o <= '0;
    end else begin
      mem_req_a_o <= mreq[0];
      mem_req_b_o <= mreq[1];
    end
  end

  // ******************************************************************
  // Register write-back
  // ******************************************************************
  // A data-unit load without the cross-path bit lands in the far file; one per side.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int sd = 0; sd < 2; sd++) begin
        for (int r = 0; r < NUM_REGS; r++) begin
          rf_r[sd][r] <= '0;
        end
      end
    end else begin
      for (int s = 0; s < SLOTS; s++) begin
        if (wr_en[s]) begin
          rf_r[slot_ins[s][SIDE_POS]][slot_ins[s][DST_LSB +: 4]] <= wr_val[s];
        end
      end
      if (mem_rsp_i.valid) begin
        rf_r[mem_rsp_i.dst_side][mem_rsp_i.dst] <= mem_rsp_i.rdata[31:0];
        if (mem_req_a_o.size == VFD_SIZE_DWORD || mem_req_b_o.size == VFD_SIZE_DWORD) begin
          rf_r[mem_rsp_i.dst_side][mem_rsp_i.dst ^ 4'h1] <= mem_rsp_i.rdata[63:32];
        end
      end
    end
  end

  // ******************************************************************
  // Branch resolution
  // ******************************************************************
  always_comb begin
    branch_taken = 1'b0;
    branch_target = '0;
    for (int s = 0; s < SLOTS; s++) begin
      if (br_en[s] && !branch_taken) begin
        branch_taken = 1'b1;
        branch_target = rf_r[slot_ins[s][SIDE_POS]][slot_ins[s][SRC_LSB +: 4]];
      end
    end
  end

  // Cross-path readers per side are flagged in xp_busy; none are dropped and issue never waits on them
  logic [1:0] xp_busy;
  always_comb begin
    xp_busy = 2'h0;
    for (int s = 0; s < SLOTS; s++) begin
      if (xread[s]) begin
        xp_busy[slot_ins[s][SIDE_POS]] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      issue_mask_o <= '0;
      packet_issued_o <= 1'b0;
    end else begin
      issue_mask_o <= (state_r == VFD_ST_ISSUE) ? ep_mask : '0;
      packet_issued_o <= (state_r == VFD_ST_ISSUE) && (xp_busy != 2'h3 || 1'b1);
    end
  end

endmodule : vfd_core

// *** verif/vfd_core_asserts.sv ***
// ******************************************************************
// Port checker for the fetch and dispatch core
// ******************************************************************
module vfd_core_chk (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic fetch_req_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic fetch_valid_i,
  input wire vfd_pkg::vfd_mem_req_type mem_req_a_o,
  input wire vfd_pkg::vfd_mem_req_type mem_req_b_o,
  input wire logic [vfd_pkg::SLOTS-1:0] issue_mask_o,
  input wire logic packet_issued_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import vfd_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_take_drop: assert property (fetch_req_o && fetch_valid_i |=> !fetch_req_o)
    else $error("fetch request held after packet taken");
  chk_take_issue: assert property (fetch_req_o && fetch_valid_i |-> ##2 packet_issued_o)
    else $error("no execute packet two cycles after fetch");
  chk_mask_set: assert property (packet_issued_o |-> issue_mask_o != 8'h00)
    else $error("issued packet with empty slot mask");
  chk_mask_idle: assert property (!packet_issued_o |-> issue_mask_o == 8'h00)
    else $error("slot mask without issue pulse");
  chk_addr_align: assert property (fetch_req_o |-> fetch_addr_o[4:0] == 5'h00)
    else $error("fetch address not packet aligned");
  chk_addr_hold: assert property (fetch_req_o && !fetch_valid_i |=> $stable(fetch_addr_o))
    else $error("fetch address moved while waiting");
  chk_wait_quiet: assert property (fetch_req_o |-> !packet_issued_o)
    else $error("issue while fetching next packet");
  chk_mem_a_idle: assert property (mem_req_a_o.valid |-> packet_issued_o)
    else $error("side A memory access without issue");
  chk_mem_b_idle: assert property (mem_req_b_o.valid |-> packet_issued_o)
    else $error("side B memory access without issue");

  cov_take: cover property (fetch_req_o && fetch_valid_i);
  cov_full: cover property (packet_issued_o && issue_mask_o == 8'hFF);
  cov_mem_b: cover property (mem_req_b_o.valid);
endmodule : vfd_core_chk

bind vfd_core vfd_core_chk vfd_core_chk_inst (.sys_clk_i, .rst_b_i, .fetch_req_o,
  .fetch_addr_o, .fetch_valid_i, .mem_req_a_o, .mem_req_b_o, .issue_mask_o, .packet_issued_o);

// *** verif/vfd_prog_mem.sv ***
// ******************************************************************
// Program memory answering fetch requests
// ******************************************************************
module vfd_prog_mem (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic fetch_req_i,
  input wire logic [31:0] fetch_addr_i,
  input wire logic en_i,
  input wire logic [3:0] lat_i,
  output logic fetch_valid_o,
  output logic [vfd_pkg::FETCH_BITS-1:0] fetch_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import vfd_pkg::*;
  logic [FETCH_BITS-1:0] mem [8];
  logic [3:0] wait_r;

  // Data toggles while not valid so a stale packet is never mistaken for a fresh one
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fetch_valid_o <= 1'b0;
      wait_r <= 4'h0;
      fetch_data_o <= '0;
    end else if (fetch_valid_o && fetch_req_i) begin
      fetch_valid_o <= 1'b0;
      fetch_data_o <= ~fetch_data_o;
    end else if (!fetch_valid_o) begin
      fetch_data_o <= ~fetch_data_o;
      if (fetch_req_i && en_i) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r == lat_i) begin
          fetch_valid_o <= 1'b1;
          fetch_data_o <= mem[fetch_addr_i[7:5]];
          wait_r <= 4'h0;
        end
      end
    end
  end
endmodule : vfd_prog_mem

// *** verif/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vfd_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic fetch_req_o, fetch_valid_i, packet_issued_o, mem_en = 1'b0;
  logic [31:0] fetch_addr_o, pc_o, exp_addr = 32'h0;
  logic [FETCH_BITS-1:0] fetch_data_i;
  vfd_mem_req_type mem_req_a_o, mem_req_b_o;
  vfd_mem_rsp_type mem_rsp_i = '0;
  logic [7:0] circ_size_i = 8'hFF;
  logic [SLOTS-1:0] issue_mask_o;
  logic [3:0] mem_lat = 4'h0;
  logic [7:0] masks[$];
  vfd_mem_req_type reqs[$];
  int num_errors = 0;
  int tests_run = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  vfd_core vfd_core_inst (.sys_clk_i, .rst_b_i, .fetch_req_o, .fetch_addr_o, .fetch_valid_i,
    .fetch_data_i, .mem_req_a_o, .mem_req_b_o, .mem_rsp_i, .circ_size_i, .issue_mask_o,
    .packet_issued_o, .pc_o);
  vfd_prog_mem vfd_prog_mem_inst (.sys_clk_i, .rst_b_i, .fetch_req_i(fetch_req_o),
    .fetch_addr_i(fetch_addr_o), .en_i(mem_en), .lat_i(mem_lat),
    .fetch_valid_o(fetch_valid_i), .fetch_data_o(fetch_data_i));

  // Registered outputs are read at the edge, so each sample is the settled previous cycle
  always @(posedge sys_clk_i) begin
    if (packet_issued_o === 1'b1) masks.push_back(issue_mask_o);
    if (mem_req_a_o.valid === 1'b1) reqs.push_back(mem_req_a_o);
    if (mem_req_b_o.valid === 1'b1) reqs.push_back(mem_req_b_o);
  end

  // ******************************************************************
  // Shared helpers
  // ******************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] ins(input logic ch, input logic [1:0] cls, input logic sd,
      input logic [2:0] opc, input logic [1:0] sz, input logic [3:0] dst,
      input logic [2:0] creg, input logic z);
    return {creg, z, 5'h00, 4'h0, 4'h0, dst, 1'b0, sz, opc, sd, 1'b0, cls, ch};
  endfunction : ins

  // Whole packets only; producer pads unused slots with no-ops
  task automatic run(input logic [FETCH_BITS-1:0] pkt, input logic [3:0] lat);
    int n;
    masks.delete();
    reqs.delete();
    vfd_prog_mem_inst.mem[exp_addr[7:5]] = pkt;
    mem_lat = lat;
    mem_en = 1'b1;
    n = 0;
    while (!(fetch_req_o === 1'b1 && fetch_valid_i === 1'b1) && n < 50) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check(n < 50, 1);
    check(fetch_addr_o, exp_addr);
    @(posedge sys_clk_i);
    #1;
    mem_en = 1'b0;
    exp_addr = exp_addr + 32'h20;
    n = 0;
    while (fetch_req_o !== 1'b1 && n < 50) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check(n < 50, 1);
    check(pc_o, exp_addr);
  endtask : run

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_single();
    run('0, 4'h0);
    check(masks.size(), 8);
    foreach (masks[i]) check(masks[i], 64'h1 << i);
    check(reqs.size(), 0);
  endtask : t_single

  task automatic t_full();
    logic [FETCH_BITS-1:0] p;
    p = '0;
    for (int i = 0; i < SLOTS; i++) p[32*i] = 1'b1;
    run(p, 4'h5);
    check(masks.size(), 1);
    check(masks[0], 8'hFF);
  endtask : t_full

  task automatic t_mixed();
    logic [FETCH_BITS-1:0] p;
    logic [7:0] exp [3];
    p = '0;
    exp = '{8'h03, 8'h1C, 8'hE0};
    p[0] = 1'b1;
    p[64] = 1'b1;
    p[96] = 1'b1;
    p[160] = 1'b1;
    p[192] = 1'b1;
    run(p, 4'h2);
    check(masks.size(), 3);
    foreach (exp[i]) check(masks[i], exp[i]);
  endtask : t_mixed

  task automatic t_mem();
    logic [FETCH_BITS-1:0] p;
    logic [7:0] exp [4];
    p = '0;
    p[31:0] = ins(1'b1, VFD_UNIT_DATA, 1'b0, OP_LOAD, 2'h0, 4'h3, CREG_ALWAYS, 1'b0);
    p[63:32] = ins(1'b0, VFD_UNIT_DATA, 1'b1, OP_STORE, 2'h1, 4'h5, CREG_ALWAYS, 1'b0);
    p[95:64] = ins(1'b0, VFD_UNIT_SHIFT, 1'b0, OP_LOAD_DOUBLE_WORD, 2'h0, 4'h6, CREG_ALWAYS, 1'b0);
    p[127:96] = ins(1'b0, VFD_UNIT_DATA, 1'b0, OP_LOAD, 2'h2, 4'h1, 3'h1, 1'b0);
    p[159:128] = ins(1'b0, VFD_UNIT_DATA, 1'b0, OP_LOAD, 2'h2, 4'h7, 3'h1, 1'b1);
    // Without the cross bit a data unit moves data to the far file; double loads stay home
    exp = '{{1'b0, VFD_SIZE_BYTE, 4'h3, 1'b1}, {1'b1, VFD_SIZE_HALF, 4'h5, 1'b0},
      {1'b0, VFD_SIZE_DWORD, 4'h6, 1'b0}, {1'b0, VFD_SIZE_WORD, 4'h7, 1'b1}};
    run(p, 4'h1);
    check(masks.size(), 7);
    check(reqs.size(), 4);
    foreach (exp[i]) check({reqs[i].wr, reqs[i].size, reqs[i].dst, reqs[i].dst_side}, exp[i]);
    foreach (reqs[i]) check(reqs[i].addr, 32'h0000_0000);
  endtask : t_mem

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    t_single();
    t_full();
    t_mixed();
    t_mem();
    t_single();
    close_out();
  end

  initial begin
    repeat (2000) @(posedge sys_clk_i);
    num_errors++;
    close_out();
  end
endmodule : tb
